// File: afc_cfg.svh
// Purpose: Register offsets, field positions, reset values and sizes.
// Assumes: Word-indexed register bus; byte address is four times index.
// Notes:   Definitions only.
`ifndef AFC_CFG_SVH
`define AFC_CFG_SVH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define AFC_ADDR_W 8
`define AFC_ADDR_SETUP 8'h3A
`define AFC_ADDR_FLAGS 8'h3B
`define AFC_ADDR_MAIN 8'h3C
`define AFC_ADDR_DATA 8'h3D

// ----------------------------------------------------------------------
// Setup register layout
// ----------------------------------------------------------------------
`define AFC_SETUP_W 24
`define AFC_SETUP_RST 24'h040200
`define AFC_SETUP_WMASK 24'h0FFFFF
`define AFC_TGT_MSB 7
`define AFC_TGT_LSB 0
`define AFC_IEN_MSB 14
`define AFC_IEN_LSB 8
`define AFC_MODE_MSB 17
`define AFC_MODE_LSB 16
`define AFC_MODE_OFF 2'h0
`define AFC_MODE_FILL 2'h1

// ----------------------------------------------------------------------
// Flag register layout
// ----------------------------------------------------------------------
`define AFC_FLAGS_RST 8'h01
`define AFC_F_EMPTY 0
`define AFC_F_TGT 1
`define AFC_F_OVR 2
`define AFC_F_LOW 3
`define AFC_F_UP 4
`define AFC_F_RERR 5
`define AFC_F_WERR 6
`define AFC_F_SUM 7
`define AFC_MAIN_ERR_BIT 6

// ----------------------------------------------------------------------
// Storage sizes
// ----------------------------------------------------------------------
`define AFC_IDX_W 8
`define AFC_CNT_W 9
`define AFC_DEPTH 9'h100
`define AFC_SAMPLE_W 16

`endif

// File: afc_conv_src.sv
// Purpose: Conversion engine model that feeds results into the FIFO.
// Assumes: One result per call, pulse of one cycle.
// Notes:   Data lines show the inverse once the pulse has passed.
`timescale 1ns/10ps
module afc_conv_src
  import afc_pkg::*;
(
  input wire logic sys_clk,          // system clock
  output logic conv_valid,           // result strobe
  output afc_sample_type conv_data,  // result value
  output logic conv_above_upper,     // over upper limit
  output logic conv_below_lower      // under lower limit
);
  initial begin
    conv_valid = 1'b0;
    conv_data = 16'h0000;
    conv_above_upper = 1'b0;
    conv_below_lower = 1'b0;
  end

  // A stale value would hide a sampling slip, so the lines are inverted.
  task automatic send(input afc_sample_type d, input logic up,
                      input logic lo);
    @(posedge sys_clk);
    conv_valid <= 1'b1;
    conv_data <= d;
    conv_above_upper <= up;
    conv_below_lower <= lo;
    @(posedge sys_clk);
    conv_valid <= 1'b0;
    conv_data <= ~d;
    conv_above_upper <= ~up;
    conv_below_lower <= ~lo;
    @(posedge sys_clk);
  endtask
endmodule

// File: afc_fifo_ctrl.sv
// Purpose: Control, flags and interrupt of the conversion-result FIFO.
// Assumes: Avalon-MM slave with word indices; one clock, async reset.
// Notes:   Waitrequest is registered; an access takes two edges, more when a data read is refused.
//
// What this block does
// - Streaming full: drop oldest, store new, overrun.
// - Bit 14 gates write-failure flag onto interrupt.
// - Bit 13 gates read-failure flag onto interrupt.
// - Bit 12 gates upper-limit flag onto interrupt.
// - Bit 11 gates lower-limit flag onto interrupt.
// - Bit 10 gates overrun flag onto interrupt.
// - Bit 9 resets to one, gates target flag.
// - Empty interrupt asserts with the empty flag.
// - Target 0x00 means 256, else literal count.
// - Target flag sets when count equals target.
// - Condition flags other than empty only in fill or streaming mode.
// - Flag register read-only, bit 7 summarises errors.
// - Summary error also sets main status error.
// - Mode 00 off, 01 fill, 1x streaming.
// - Fill mode keeps first N, discards set overrun.
// - Read colliding with conversion fails; grant clears.
// - Conversion lost to read or target: write failure.
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "afc_cfg.svh"
module afc_fifo_ctrl
  import afc_pkg::*;
(
  input wire logic sys_clk,                 // 250 MHz clock
  input wire logic arst_n,                  // async reset, active low
  input wire logic [`AFC_ADDR_W-1:0] avs_address, // word index
  input wire logic avs_read,                // read request
  input wire logic avs_write,               // write request
  input wire logic [31:0] avs_writedata,    // write data
  input wire logic [3:0] avs_byteenable,    // byte lanes
  output logic [31:0] avs_readdata,         // read data
  output logic avs_waitrequest,             // stall
  input wire logic conv_valid,              // new conversion, one cycle
  input wire afc_sample_type conv_data,     // conversion result
  input wire logic conv_above_upper,        // result at or over upper limit
  input wire logic conv_below_lower,        // result at or under lower limit
  output logic fifo_irq,                    // FIFO interrupt, high
  output logic dev_err                      // main status error summary
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  logic [`AFC_SETUP_W-1:0] setup_reg;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  afc_idx_type wr_ptr_reg;
  afc_idx_type rd_ptr_reg;
  afc_cnt_type count_reg;
  afc_cnt_type count_next;
  logic held_reg;
  logic held_next;
  logic rd_busy_reg;
  afc_sample_type last_conv_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic irq_reg;
  logic err_reg;

  afc_mem_if mem_bus ();

  afc_sample_store u_store (
    .sys_clk (sys_clk),
    .mem     (mem_bus.mem)
  );

  // --------------------------------------------------------------------
  // Mode and target decode
  // --------------------------------------------------------------------
  wire [1:0] mode_field = setup_reg[`AFC_MODE_MSB:`AFC_MODE_LSB];
  afc_mode_type mode;
  assign mode = (mode_field == `AFC_MODE_OFF) ? AFC_OFF :
                (mode_field == `AFC_MODE_FILL) ? AFC_FILL :
                AFC_STREAM;
  wire mode_on = (mode != AFC_OFF);
  wire mode_fill = (mode == AFC_FILL);
  wire mode_stream = (mode == AFC_STREAM);
  wire [7:0] tgt_field = setup_reg[`AFC_TGT_MSB:`AFC_TGT_LSB];
  wire [6:0] ien = setup_reg[`AFC_IEN_MSB:`AFC_IEN_LSB];
  // A zero target stands for the whole depth.
  wire afc_cnt_type target = (tgt_field == 8'h00) ? `AFC_DEPTH :
                             {1'b0, tgt_field};

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  wire hit_setup = (avs_address == `AFC_ADDR_SETUP);
  wire hit_flags = (avs_address == `AFC_ADDR_FLAGS);
  wire hit_main = (avs_address == `AFC_ADDR_MAIN);
  wire hit_data = (avs_address == `AFC_ADDR_DATA);
  wire req_live = (avs_read | avs_write) & wait_reg;
  // A data read meeting a conversion loses; it is retried next cycle.
  wire refuse = req_live & avs_read & hit_data & mode_on &
                conv_valid;
  wire grant = req_live & ~refuse;
  wire fifo_empty = (count_reg == {`AFC_CNT_W{1'b0}});
  wire fifo_full = (count_reg == `AFC_DEPTH);
  wire data_rd = grant & avs_read & hit_data & mode_on;
  wire pop = data_rd & ~fifo_empty;
  wire setup_wr = grant & avs_write & hit_setup;
  wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                         {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [`AFC_SETUP_W-1:0] wr_mask =
    be_mask[`AFC_SETUP_W-1:0] & `AFC_SETUP_WMASK;
  // Bit 15 is stored as written; the host keeps it at zero.
  wire [`AFC_SETUP_W-1:0] setup_next = setup_wr ?
    ((setup_reg & ~wr_mask) | (avs_writedata[`AFC_SETUP_W-1:0] & wr_mask))
    : setup_reg;

  // --------------------------------------------------------------------
  // Admission of conversions
  // --------------------------------------------------------------------
  // The cycle after a granted pop the read port is busy, so a result
  // arriving then cannot be stored.
  wire conv_on = conv_valid & mode_on;
  wire lost_busy = conv_on & rd_busy_reg;
  wire lost_held = conv_on & ~rd_busy_reg & mode_fill & held_reg;
  wire store = conv_on & ~rd_busy_reg & ~(mode_fill & held_reg);
  wire overwrite = store & mode_stream & fifo_full;

  always_comb begin
    count_next = count_reg;
    if (!mode_on) begin
      count_next = {`AFC_CNT_W{1'b0}};
    end else if (store & ~overwrite) begin
      count_next = count_reg + 1'b1;
    end else if (pop) begin
      count_next = count_reg - 1'b1;
    end
  end

  wire next_empty = (count_next == {`AFC_CNT_W{1'b0}});
  wire at_target = (count_next == target);

  // Fill mode treats the FIFO as full from the target until empty.
  always_comb begin
    held_next = held_reg;
    if (!mode_fill || next_empty) begin
      held_next = 1'b0;
    end else if (store & at_target) begin
      held_next = 1'b1;
    end
  end

  assign mem_bus.wr_en = store;
  assign mem_bus.wr_idx = wr_ptr_reg;
  assign mem_bus.wr_data = conv_data;
  assign mem_bus.rd_idx = rd_ptr_reg;

  // --------------------------------------------------------------------
  // Condition flags
  // --------------------------------------------------------------------
  // Each flag: set wins over the clear taken on emptying.
  wire set_tgt = store & at_target;
  wire set_ovr = overwrite | lost_held;
  wire set_werr = lost_busy | lost_held;
  wire set_up = store & conv_above_upper;
  wire set_low = store & conv_below_lower;
  wire clr_rerr = data_rd | next_empty;

  always_comb begin
    flags_next = 8'h00;
    flags_next[`AFC_F_EMPTY] = next_empty;
    flags_next[`AFC_F_TGT] = set_tgt |
      (flags_reg[`AFC_F_TGT] & ~next_empty);
    flags_next[`AFC_F_OVR] = set_ovr |
      (flags_reg[`AFC_F_OVR] & ~next_empty);
    flags_next[`AFC_F_LOW] = set_low |
      (flags_reg[`AFC_F_LOW] & ~next_empty);
    flags_next[`AFC_F_UP] = set_up |
      (flags_reg[`AFC_F_UP] & ~next_empty);
    flags_next[`AFC_F_RERR] = refuse |
      (flags_reg[`AFC_F_RERR] & ~clr_rerr);
    flags_next[`AFC_F_WERR] = set_werr |
      (flags_reg[`AFC_F_WERR] & ~next_empty);
    if (!mode_on) begin
      flags_next[`AFC_F_WERR:`AFC_F_TGT] = 6'h00;
    end
    flags_next[`AFC_F_SUM] = flags_next[`AFC_F_WERR] |
      flags_next[`AFC_F_RERR] | flags_next[`AFC_F_OVR];
  end

  // Interrupt is registered from the next flags so that it rises in
  // the same cycle as the flag that causes it.
  wire irq_next = mode_on &
    (|(flags_next[`AFC_F_WERR:`AFC_F_EMPTY] & ien));

  // --------------------------------------------------------------------
  // Read data selection
  // --------------------------------------------------------------------
  wire afc_sample_type data_word = !mode_on ? last_conv_reg :
    (fifo_empty ? {`AFC_SAMPLE_W{1'b0}} : mem_bus.rd_data);
  wire [31:0] main_word = {24'h000000, 1'b0, flags_reg[`AFC_F_SUM],
                           6'h00};
  wire [31:0] rd_mux =
    hit_setup ? {8'h00, setup_reg & `AFC_SETUP_WMASK} :
    hit_flags ? {24'h000000, flags_reg} :
    hit_main ? main_word :
    hit_data ? {16'h0000, data_word} : 32'h00000000;

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      setup_reg <= `AFC_SETUP_RST;
      flags_reg <= `AFC_FLAGS_RST;
      count_reg <= {`AFC_CNT_W{1'b0}};
      held_reg <= 1'b0;
      rd_busy_reg <= 1'b0;
    end else begin
      setup_reg <= setup_next;
      flags_reg <= flags_next;
      count_reg <= count_next;
      held_reg <= held_next;
      rd_busy_reg <= pop;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= {`AFC_IDX_W{1'b0}};
      rd_ptr_reg <= {`AFC_IDX_W{1'b0}};
    end else if (!mode_on) begin
      wr_ptr_reg <= {`AFC_IDX_W{1'b0}};
      rd_ptr_reg <= {`AFC_IDX_W{1'b0}};
    end else begin
      wr_ptr_reg <= wr_ptr_reg + {{(`AFC_IDX_W-1){1'b0}}, store};
      rd_ptr_reg <= rd_ptr_reg +
        {{(`AFC_IDX_W-1){1'b0}}, pop | overwrite};
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_conv_reg <= {`AFC_SAMPLE_W{1'b0}};
    end else if (conv_valid) begin
      last_conv_reg <= conv_data;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      wait_reg <= ~grant;
      rdata_reg <= (grant & avs_read) ? rd_mux : rdata_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
      err_reg <= flags_next[`AFC_F_SUM];
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign fifo_irq = irq_reg;
  assign dev_err = err_reg;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_full_arrival;
    mode_stream && fifo_full && conv_valid && !rd_busy_reg;
  endsequence

  sequence s_drop_seen;
    flags_reg[`AFC_F_OVR] && fifo_full && $stable(count_reg);
  endsequence

  chk_stream_drop_oldest: assert property (
    s_full_arrival |=> s_drop_seen)
    else $error("streaming overwrite lost overrun or count");
  chk_werr_gate: assert property (
    $past(mode_on && ien[6]) && flags_reg[`AFC_F_WERR] |-> fifo_irq)
    else $error("write failure did not raise interrupt");
  chk_rerr_gate: assert property (
    $past(mode_on && ien[5]) && flags_reg[`AFC_F_RERR] |-> fifo_irq)
    else $error("read failure did not raise interrupt");
  chk_upper_gate: assert property (
    $past(mode_on && ien[4]) && flags_reg[`AFC_F_UP] |-> fifo_irq)
    else $error("upper limit did not raise interrupt");
  chk_lower_gate: assert property (
    $past(mode_on && ien[3]) && flags_reg[`AFC_F_LOW] |-> fifo_irq)
    else $error("lower limit did not raise interrupt");
  chk_ovr_gate: assert property (
    $past(mode_on && ien[2]) && flags_reg[`AFC_F_OVR] |-> fifo_irq)
    else $error("overrun did not raise interrupt");
  chk_irq_masked: assert property (
    fifo_irq |-> $past(mode_on) &&
    (|(flags_reg[`AFC_F_WERR:`AFC_F_EMPTY] & $past(ien))))
    else $error("interrupt without an enabled flag");
  chk_empty_irq: assert property (
    $rose(flags_reg[`AFC_F_EMPTY]) && $past(mode_on && ien[0])
    |-> fifo_irq)
    else $error("empty interrupt late");
  chk_target_flag: assert property (
    store && (count_next == target) |=> flags_reg[`AFC_F_TGT])
    else $error("target flag not set");
  // The zero code must mean a full store, never an empty one.
  chk_target_code: assert property (
    $rose(held_reg) |-> !fifo_empty &&
    (count_reg[`AFC_TGT_MSB:`AFC_TGT_LSB] == tgt_field))
    else $error("fill target not met by stored count");
  chk_off_quiet: assert property (
    !mode_on |=> flags_reg[`AFC_F_WERR:`AFC_F_TGT] == 6'h00)
    else $error("flag active in disabled mode");
  chk_summary_err: assert property (
    flags_reg[`AFC_F_SUM] == (flags_reg[`AFC_F_WERR] |
    flags_reg[`AFC_F_RERR] | flags_reg[`AFC_F_OVR]) &&
    dev_err == flags_reg[`AFC_F_SUM])
    else $error("summary error mismatch");
  chk_fill_hold: assert property (
    mode_fill && held_reg && conv_valid && !rd_busy_reg
    |=> flags_reg[`AFC_F_OVR] && flags_reg[`AFC_F_WERR] &&
    $stable(wr_ptr_reg))
    else $error("fill mode stored past target");
  chk_read_refuse: assert property (
    refuse |=> flags_reg[`AFC_F_RERR] && avs_waitrequest)
    else $error("colliding read not refused");
  chk_busy_drop: assert property (
    conv_on && rd_busy_reg |=> flags_reg[`AFC_F_WERR] &&
    $stable(wr_ptr_reg))
    else $error("conversion not dropped while read busy");
endmodule

// File: afc_mem_if.sv
// Purpose: Carries write and read traffic to the sample storage.
// Assumes: One write port and one asynchronous read port.
// Notes:   The control side drives indices and write data.
`timescale 1ns/10ps
interface afc_mem_if;
  import afc_pkg::*;
  logic wr_en;
  afc_idx_type wr_idx;
  afc_sample_type wr_data;
  afc_idx_type rd_idx;
  afc_sample_type rd_data;
  modport ctl (output wr_en, output wr_idx, output wr_data,
               output rd_idx, input rd_data);
  modport mem (input wr_en, input wr_idx, input wr_data,
               input rd_idx, output rd_data);
endinterface

// File: afc_pkg.sv
// Purpose: Shared types of the sample FIFO control block.
// Assumes: afc_cfg.svh supplies the sizes.
// Notes:   Types only.
`include "afc_cfg.svh"
package afc_pkg;
  typedef logic [`AFC_SAMPLE_W-1:0] afc_sample_type;
  typedef logic [`AFC_IDX_W-1:0] afc_idx_type;
  typedef logic [`AFC_CNT_W-1:0] afc_cnt_type;
  typedef enum {AFC_OFF, AFC_FILL, AFC_STREAM} afc_mode_type;
endpackage

// File: afc_sample_store.sv
// Purpose: Flip-flop storage of 256 conversion results.
// Assumes: Indices are always in range.
// Notes:   No reset on the array; occupancy is tracked by the control.
`timescale 1ns/10ps
`include "afc_cfg.svh"
module afc_sample_store
  import afc_pkg::*;
(
  input wire logic sys_clk, // system clock
  afc_mem_if.mem mem        // storage port
);
  afc_sample_type store_reg [`AFC_DEPTH];

  always_ff @(posedge sys_clk) begin
    if (mem.wr_en) begin
      store_reg[mem.wr_idx] <= mem.wr_data;
    end
  end

  assign mem.rd_data = store_reg[mem.rd_idx];
endmodule

// File: tb.sv
// Purpose: Self-checking bench of the FIFO control block.
// Assumes: Avalon-MM master tasks; model kept with a queue.
// Notes:   Conversions are spaced so none follows a pop directly, except in the lost-conversion test.
`timescale 1ns/10ps
`include "afc_cfg.svh"
module tb;
  import afc_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic conv_valid;
  afc_sample_type conv_data;
  logic conv_above_upper;
  logic conv_below_lower;
  logic fifo_irq;
  logic dev_err;
  int n_fail = 0;
  int n_tests = 0;
  int q[$];
  int mode = 0;
  int tgt = 256;
  int last = 0;
  bit held = 0;
  logic [7:0] fl = 8'h01;
  logic [23:0] setup = 24'h040200;

  always #2 sys_clk = ~sys_clk;

  afc_fifo_ctrl i_dut(.sys_clk(sys_clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .conv_valid(conv_valid),
    .conv_data(conv_data), .conv_above_upper(conv_above_upper),
    .conv_below_lower(conv_below_lower), .fifo_irq(fifo_irq),
    .dev_err(dev_err));

  afc_conv_src i_src(.sys_clk(sys_clk), .conv_valid(conv_valid),
    .conv_data(conv_data), .conv_above_upper(conv_above_upper),
    .conv_below_lower(conv_below_lower));

  // ----------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_pin(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic [23:0] m;
    bus(1'b1, a, d, r);
    if (a == `AFC_ADDR_SETUP) begin
      m = {{8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
           {8{avs_byteenable[0]}}} & `AFC_SETUP_WMASK;
      setup = (setup & ~m) | (d[23:0] & m);
      mode = setup[17:16];
      tgt = (setup[7:0] == 8'h00) ? 256 : setup[7:0];
      if (mode == 0) begin
        q.delete();
        fl = 8'h01;
        held = 0;
      end
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h00000000, r);
    cmp_reg(r, exp);
  endtask

  // ----------------------------------------------------------------
  // Model steps
  // ----------------------------------------------------------------
  task automatic conv(input bit busy = 1'b0);
    logic [15:0] d;
    logic up;
    logic lo;
    d = 16'($urandom);
    up = 1'($urandom);
    lo = 1'($urandom);
    i_src.send(d, up, lo);
    if (busy) fl[6] = 1'b1;
    else if (mode == 0) last = d;
    else if (mode == 1 && held) begin
      fl[6] = 1'b1;
      fl[2] = 1'b1;
    end else begin
      if (q.size() == 256) begin
        void'(q.pop_front());
        fl[2] = 1'b1;
      end
      q.push_back(d);
      fl[0] = 1'b0;
      fl[4] = fl[4] | up;
      fl[3] = fl[3] | lo;
      if (q.size() == tgt) begin
        fl[1] = 1'b1;
        held = (mode == 1);
      end
    end
    fl[7] = fl[6] | fl[5] | fl[2];
  endtask

  task automatic pop_chk();
    int e;
    if (mode == 0) e = last;
    else if (q.size() == 0) e = 0;
    else e = q.pop_front();
    rd_chk(`AFC_ADDR_DATA, 32'(e));
    if (mode != 0 && q.size() == 0) begin
      fl = 8'h01;
      held = 0;
    end
  endtask

  task automatic check_flags();
    logic irq;
    irq = (mode != 0) && ((fl[6:0] & setup[14:8]) != 7'h00);
    rd_chk(`AFC_ADDR_FLAGS, 32'(fl));
    rd_chk(`AFC_ADDR_MAIN, 32'(fl[7]) << 6);
    cmp_pin(fifo_irq, irq);
    cmp_pin(dev_err, fl[7]);
  endtask

  task automatic wrap_up();
    $display("n_tests=%0d n_fail=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h0d49f8bd));
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rd_chk(`AFC_ADDR_SETUP, 32'h00040200);
    check_flags();
    wr(`AFC_ADDR_FLAGS, 32'h000000FF);
    rd_chk(`AFC_ADDR_FLAGS, 32'h00000001);
    rd_chk(8'h10, 32'h00000000);
    repeat (3) conv();
    check_flags();
    pop_chk();
    // Host keeps setup bit 15 at zero in every write.
    wr(`AFC_ADDR_SETUP, 32'h00017E04);
    repeat (4) conv();
    check_flags();
    repeat (2) conv();
    check_flags();
    repeat (5) pop_chk();
    check_flags();
    wr(`AFC_ADDR_SETUP, 32'h00000000);
    wr(`AFC_ADDR_SETUP, 32'h00020400);
    repeat (256) conv();
    check_flags();
    conv();
    check_flags();
    repeat (3) pop_chk();
    // A data read meeting a conversion is refused once, then granted.
    fork
      pop_chk();
      conv();
    join
    check_flags();
    // A conversion landing the cycle after a pop is lost.
    fork
      pop_chk();
      begin
        @(posedge sys_clk);
        conv(1'b1);
      end
    join
    check_flags();
    for (int b = 8; b < 15; b++) begin
      wr(`AFC_ADDR_SETUP, 32'h00030000 | (32'h1 << b));
      check_flags();
    end
    wr(`AFC_ADDR_SETUP, 32'h00030100);
    while (q.size() > 0) pop_chk();
    check_flags();
    avs_byteenable <= 4'h2;
    wr(`AFC_ADDR_SETUP, 32'h00FF7FFF);
    avs_byteenable <= 4'hF;
    rd_chk(`AFC_ADDR_SETUP, 32'h00037F00);
    check_flags();
    wrap_up();
  end

  // The tests take under two thousand cycles; 10000 leaves ample margin.
  initial begin
    #40000;
    n_fail++;
    wrap_up();
  end
endmodule
